// >>> design/can_buf_addr.sv
`timescale 1ns/1ps
`default_nettype none
module can_buf_addr
	import can_ctl_pkg::*;
(
	// layout
	input  wire logic [31:0]               base_i,
	input  wire logic [NUM_FIFO-1:0][4:0]  fsize_i,
	input  wire logic [FIFO_W-1:0]         sel_i,
	// start of the selected fifo
	output logic      [31:0]               addr_o
);

	logic [31:0] acc;

	// each fifo follows the ones before it, sized fsize+1 messages
	always_comb
	begin
		acc = {base_i[31:2], 2'h0};
		for (int k = 0; k < NUM_FIFO; k++)
		begin
			if (FIFO_W'(k) < sel_i)
			begin
				acc = acc + 32'(MSG_BYTES) * (32'(fsize_i[k]) + 32'h1);
			end
		end
		addr_o = acc;
	end

endmodule
`default_nettype wire

// >>> design/can_ctl_pkg.sv
package can_ctl_pkg;

	// ----------------------------------------------------------------
	// geometry
	// ----------------------------------------------------------------
	localparam int NUM_FIFO  = 32;
	localparam int FIFO_W    = 5;
	localparam int ADR_W     = 12;
	localparam int NUM_SRC   = 9;
	localparam int MSG_BYTES = 16;

	// ----------------------------------------------------------------
	// register byte offsets
	// ----------------------------------------------------------------
	localparam logic [ADR_W-1:0] OFS_INT      = 12'h000;
	localparam logic [ADR_W-1:0] OFS_CON      = 12'h004;
	localparam logic [ADR_W-1:0] OFS_BASE     = 12'h008;
	localparam logic [ADR_W-1:0] OFS_FIFO_LO  = 12'h080;
	localparam logic [ADR_W-1:0] OFS_FIFO_HI  = 12'h0FC;

	// ----------------------------------------------------------------
	// module control fields
	// ----------------------------------------------------------------
	localparam int          CON_MODE_LSB = 21;
	localparam int          CON_MODE_MSB = 23;
	localparam int          CON_ON_BIT   = 15;
	localparam logic [2:0]  MODE_CONFIG  = 3'h4;
	localparam logic [2:0]  MODE_RESET   = 3'h4;

	// ----------------------------------------------------------------
	// interrupt sources: index into enable and flag vectors
	// ----------------------------------------------------------------
	localparam int SRC_TX   = 0;
	localparam int SRC_RX   = 1;
	localparam int SRC_TMR  = 2;
	localparam int SRC_MODE = 3;
	localparam int SRC_RXOV = 4;
	localparam int SRC_SERR = 5;
	localparam int SRC_CERR = 6;
	localparam int SRC_WAKE = 7;
	localparam int SRC_IVR  = 8;
	localparam int INT_EN_LSB = 16;

	// ----------------------------------------------------------------
	// fifo control fields
	// ----------------------------------------------------------------
	localparam int FC_SIZE_LSB = 16;
	localparam int FC_SIZE_MSB = 20;
	localparam int FC_RESET    = 14;
	localparam int FC_FIFO_DIRECTION_TX     = 7;
	localparam int FC_ABAT     = 6;
	localparam int FC_LARB     = 5;
	localparam int FC_TERR     = 4;
	localparam int FC_SEND_REQUEST    = 3;
	localparam int FC_AUTO_REMOTE_REPLY_EN    = 2;
	localparam int FC_PRIO_MSB = 1;

endpackage

// >>> design/can_int_fifo_ctl.sv
// Operation
// - bit 31 enables the invalid-message interrupt request.
// - other enables sit at bits 30..27 and 19..16.
// - each flag sits sixteen below its enable; invalid-message at 15.
// - bits 26..20 and 10..4 of the interrupt register read zero.
// - system-error flag ignores software clears; cleared by module off.
// - fifo buffers follow one another from one 32-bit base address.
// - base address bits 1..0 are zero and read-only.
// - base address is written only in configuration mode 100.
// - fifo size and direction fields are written only in mode 100.
// - fifo bit 6 shows last message aborted (1) or completed (0).
// - aborted status changes only on completion, abort or fifo reset.
// - fifo bit 5 set when a message loses arbitration.
// - fifo bit 4 set on bus error during that fifo's send.
// - bits 5 and 4 clear on a read of that fifo's word and on fifo reset.
// - software sets send request; hardware clears it when all sent.
// - clearing a set send request asks for an abort.
// - send request writes are ignored on a receive fifo.
// - remote request sets send request when auto reply enabled.
// - two-bit priority orders transmit fifos, 11 highest.
`timescale 1ns/1ps
`default_nettype none
module can_int_fifo_ctl
	import can_ctl_pkg::*;
(
	// clock and reset
	input  wire logic                      clk_i,
	input  wire logic                      rst_i,
	// wishbone slave
	input  wire logic                      wb_cyc_i,
	input  wire logic                      wb_stb_i,
	input  wire logic                      wb_we_i,
	input  wire logic [ADR_W-1:0]          wb_adr_i,
	input  wire logic [3:0]                wb_sel_i,
	input  wire logic [31:0]               wb_dat_i,
	output logic      [31:0]               wb_dat_o,
	output logic                           wb_ack_o,
	// events from the protocol engine
	input  wire logic [NUM_SRC-1:0]        irq_event_i,
	input  wire logic [NUM_FIFO-1:0]       msg_done_i,
	input  wire logic [NUM_FIFO-1:0]       msg_aborted_i,
	input  wire logic [NUM_FIFO-1:0]       all_sent_i,
	input  wire logic [NUM_FIFO-1:0]       lost_arb_i,
	input  wire logic [NUM_FIFO-1:0]       tx_bus_err_i,
	input  wire logic [NUM_FIFO-1:0]       remote_rx_i,
	// buffer address lookup
	input  wire logic [FIFO_W-1:0]         addr_sel_i,
	output logic      [31:0]               fifo_addr_o,
	// status toward the protocol engine
	output logic                           irq_o,
	output logic      [2:0]                operating_mode_field_o,
	output logic                           module_on_o,
	output logic      [31:0]               buffer_base_addr_o,
	output logic      [NUM_FIFO-1:0]       send_request_o,
	output logic      [NUM_FIFO-1:0]       abort_req_o,
	output logic      [NUM_FIFO-1:0]       fifo_reset_o,
	output logic      [FIFO_W-1:0]         tx_fifo_sel_o,
	output logic                           tx_pending_o
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	// whole block state, registered in one place
	typedef struct packed {
		logic                      ack;
		logic [31:0]               rdata;
		logic [NUM_SRC-1:0]        irq_en;
		logic [NUM_SRC-1:0]        irq_flag;
		logic [2:0]                opmode;
		logic                      on;
		logic [29:0]               base;
		logic [NUM_FIFO-1:0]       fifo_direction_tx;
		logic [NUM_FIFO-1:0]       abat;
		logic [NUM_FIFO-1:0]       larb;
		logic [NUM_FIFO-1:0]       terr;
		logic [NUM_FIFO-1:0]       send_request;
		logic [NUM_FIFO-1:0]       auto_remote_reply_en;
		logic [NUM_FIFO-1:0]       abort_req;
		logic [NUM_FIFO-1:0]       freset;
		logic [NUM_FIFO-1:0][1:0]  prio;
		logic [NUM_FIFO-1:0][4:0]  fsize;
		logic                      irq;
		logic [31:0]               fifo_addr;
		logic [FIFO_W-1:0]         tx_sel;
		logic                      tx_pend;
	} state_s;

	// st is the flops, next_st what they take at the next edge
	state_s st;
	state_s next_st;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	// decode and merge terms shared by the next-state logic
	logic              take;
	logic              wr;
	logic              rd;
	logic [31:0]       wmask;
	logic              hit_int;
	logic              hit_con;
	logic              hit_base;
	logic              hit_fifo;
	logic [FIFO_W-1:0] fidx;
	logic              cfg_mode;
	logic [31:0]       int_word;
	logic [31:0]       int_new;
	logic [31:0]       con_new;
	logic [31:0]       base_new;
	logic [31:0]       fc_new;
	logic [31:0]       fc_word;
	logic [31:0]       calc_addr;
	logic [FIFO_W-1:0] arb_sel;
	logic              arb_valid;
	logic [NUM_FIFO-1:0] fifo_wr;
	logic [NUM_FIFO-1:0] fifo_rd;
	logic [NUM_FIFO-1:0] sw_sets_req;

	// bus decode; a raised ack blocks a second take of a held strobe,
	// so each request costs two cycles and lands on the edge raising ack
	assign take     = wb_cyc_i && wb_stb_i && !st.ack;
	assign wr       = take && wb_we_i;
	assign rd       = take && !wb_we_i;
	assign wmask    = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
	                   {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
	assign hit_int  = wb_adr_i == OFS_INT;
	assign hit_con  = wb_adr_i == OFS_CON;
	assign hit_base = wb_adr_i == OFS_BASE;
	assign hit_fifo = wb_adr_i >= OFS_FIFO_LO && wb_adr_i <= OFS_FIFO_HI
	                  && wb_adr_i[1:0] == 2'h0;
	assign fidx     = wb_adr_i[FIFO_W+1:2];
	assign cfg_mode = st.opmode == MODE_CONFIG;

	// interrupt word: enables high, flags sixteen below, gaps zero
	// gaps are tied off here, so writes to them simply vanish
	assign int_word = {st.irq_en[8:4], 7'h00, st.irq_en[3:0],
	                   st.irq_flag[8:4], 7'h00, st.irq_flag[3:0]};

	// byte-lane merge of write data into current contents
	// the fifo reset bit reads zero, so a merged write never repeats it
	assign int_new  = (int_word & ~wmask) | (wb_dat_i & wmask);
	assign con_new  = ({8'h00, st.opmode, 5'h00, st.on, 15'h0000} & ~wmask)
	                  | (wb_dat_i & wmask);
	assign base_new = ({st.base, 2'h0} & ~wmask) | (wb_dat_i & wmask);
	assign fc_word  = {11'h000, st.fsize[fidx], 8'h00, st.fifo_direction_tx[fidx],
	                   st.abat[fidx], st.larb[fidx], st.terr[fidx],
	                   st.send_request[fidx], st.auto_remote_reply_en[fidx], st.prio[fidx]};
	assign fc_new   = (fc_word & ~wmask) | (wb_dat_i & wmask);

	// ----------------------------------------------------------------
	// per-fifo access strobes
	// ----------------------------------------------------------------
	// one strobe per fifo keeps the next-state loop short; a software
	// set of the send request is marked apart because it outranks an
	// engine completion in the same cycle
	for (genvar g = 0; g < NUM_FIFO; g++)
	begin : g_fifo
		assign fifo_wr[g]     = wr && hit_fifo && fidx == FIFO_W'(g);
		assign fifo_rd[g]     = rd && hit_fifo && fidx == FIFO_W'(g);
		assign sw_sets_req[g] = fifo_wr[g] && fc_new[FC_SEND_REQUEST]
		                        && st.fifo_direction_tx[g];
	end

	// ----------------------------------------------------------------
	// submodules
	// ----------------------------------------------------------------
	// start address of the fifo that the engine asks about
	can_buf_addr u_addr
	(
		.base_i  ({st.base, 2'h0}),
		.fsize_i (st.fsize),
		.sel_i   (addr_sel_i),
		.addr_o  (calc_addr)
	);

	// winner among transmit fifos with a pending send request
	can_tx_arbiter u_arb
	(
		.pending_i (st.send_request & st.fifo_direction_tx),
		.prio_i    (st.prio),
		.sel_o     (arb_sel),
		.valid_o   (arb_valid)
	);

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb
	begin
		next_st           = st;
		next_st.ack       = take;
		next_st.abort_req = '0;
		next_st.freset    = '0;

		// read data, captured before any read side effect
		// a fifo read also clears that fifo's sticky error bits below
		if (rd)
		begin
			if (hit_int)
				next_st.rdata = int_word;
			else if (hit_con)
				next_st.rdata = {8'h00, st.opmode, 5'h00, st.on, 15'h0000};
			else if (hit_base)
				next_st.rdata = {st.base, 2'h0};
			else if (hit_fifo)
				next_st.rdata = fc_word;
			else
				next_st.rdata = 32'h0000_0000;
		end
		else
		begin
			next_st.rdata = st.rdata;
		end

		// interrupt register write, then hardware sets win
		// the system-error flag survives software writes so that a fault
		// cannot be hidden; only switching the module off clears it
		if (wr && hit_int)
		begin
			next_st.irq_en = {int_new[31:27], int_new[19:16]};
			next_st.irq_flag = {int_new[15:11], int_new[3:0]};
			next_st.irq_flag[SRC_SERR] = st.irq_flag[SRC_SERR];
		end
		if (wr && hit_con)
		begin
			next_st.opmode = con_new[CON_MODE_MSB:CON_MODE_LSB];
			next_st.on     = con_new[CON_ON_BIT];
			if (!con_new[CON_ON_BIT] && st.on)
				next_st.irq_flag[SRC_SERR] = 1'b0;
		end
		next_st.irq_flag = next_st.irq_flag | irq_event_i;

		// base address only in configuration mode
		// so the buffer layout never moves under a running engine
		if (wr && hit_base && cfg_mode)
			next_st.base = base_new[31:2];

		// per-fifo control and status; the order of the updates below
		// decides who wins when events and software meet in one cycle
		for (int k = 0; k < NUM_FIFO; k++)
		begin
			// software access to this fifo's control word
			if (fifo_wr[k])
			begin
				if (cfg_mode)
				begin
					next_st.fsize[k] = fc_new[FC_SIZE_MSB:FC_SIZE_LSB];
					next_st.fifo_direction_tx[k]  = fc_new[FC_FIFO_DIRECTION_TX];
				end
				next_st.auto_remote_reply_en[k] = fc_new[FC_AUTO_REMOTE_REPLY_EN];
				next_st.prio[k]  = fc_new[FC_PRIO_MSB:0];
				next_st.freset[k] = fc_new[FC_RESET];
				// clearing a set request only pulses the abort; the bit
				// stays up until the engine reports, so software can poll
				if (st.fifo_direction_tx[k])
				begin
					if (fc_new[FC_SEND_REQUEST])
						next_st.send_request[k] = 1'b1;
					else if (st.send_request[k])
						next_st.abort_req[k] = 1'b1;
				end
			end
			if (fifo_rd[k])
			begin
				next_st.larb[k] = 1'b0;
				next_st.terr[k] = 1'b0;
			end

			// engine completion clears the request unless set this cycle
			// a remote request below may raise it again in the same cycle
			if ((all_sent_i[k] || msg_aborted_i[k]) && !sw_sets_req[k])
				next_st.send_request[k] = 1'b0;
			if (remote_rx_i[k] && st.auto_remote_reply_en[k] && st.fifo_direction_tx[k])
				next_st.send_request[k] = 1'b1;

			// aborted status moves only on completion, abort or reset
			if (msg_aborted_i[k])
				next_st.abat[k] = 1'b1;
			else if (msg_done_i[k])
				next_st.abat[k] = 1'b0;

			// fifo reset, held one cycle as a pulse
			// reset outranks completion but not a fresh error event
			if (st.freset[k])
			begin
				next_st.abat[k]  = 1'b0;
				next_st.larb[k]  = 1'b0;
				next_st.terr[k]  = 1'b0;
				next_st.send_request[k] = 1'b0;
			end

			// sticky transmit errors, set wins over any clear
			if (lost_arb_i[k])
				next_st.larb[k] = 1'b1;
			if (tx_bus_err_i[k])
				next_st.terr[k] = 1'b1;
		end

		// registered outputs
		// irq, buffer address and arbiter result all lag one cycle
		next_st.irq       = |(st.irq_flag & st.irq_en);
		next_st.fifo_addr = calc_addr;
		next_st.tx_sel    = arb_sel;
		next_st.tx_pend   = arb_valid;
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	// synchronous reset; the block wakes in configuration mode so the
	// buffer layout can be set before the module is switched on
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			st        <= '0;
			st.opmode <= MODE_RESET;
		end
		else
		begin
			st <= next_st;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	// ports read the state flops directly, no logic after them
	assign wb_dat_o               = st.rdata;
	assign wb_ack_o               = st.ack;
	assign irq_o                  = st.irq;
	assign operating_mode_field_o = st.opmode;
	assign module_on_o            = st.on;
	assign buffer_base_addr_o     = {st.base, 2'h0};
	assign send_request_o         = st.send_request;
	assign abort_req_o            = st.abort_req;
	assign fifo_reset_o           = st.freset;
	assign fifo_addr_o            = st.fifo_addr;
	assign tx_fifo_sel_o          = st.tx_sel;
	assign tx_pending_o           = st.tx_pend;

endmodule
`default_nettype wire

// >>> design/can_tx_arbiter.sv
`timescale 1ns/1ps
`default_nettype none
module can_tx_arbiter
	import can_ctl_pkg::*;
(
	// candidates
	input  wire logic [NUM_FIFO-1:0]       pending_i,
	input  wire logic [NUM_FIFO-1:0][1:0]  prio_i,
	// winner
	output logic      [FIFO_W-1:0]         sel_o,
	output logic                           valid_o
);

	logic [1:0] best;

	// highest priority wins, lowest index on a tie
	always_comb
	begin
		sel_o   = '0;
		valid_o = 1'b0;
		best    = 2'h0;
		for (int k = NUM_FIFO - 1; k >= 0; k--)
		begin
			if (pending_i[k] && (!valid_o || prio_i[k] >= best))
			begin
				sel_o   = FIFO_W'(k);
				best    = prio_i[k];
				valid_o = 1'b1;
			end
		end
	end

endmodule
`default_nettype wire

// >>> verif/can_engine_model.sv
`timescale 1ns/1ps
`default_nettype none
module can_engine_model
	import can_ctl_pkg::*;
(
	// clock, reset and bench controls
	input  wire logic                clk_i,
	input  wire logic                rst_i,
	input  wire logic [7:0]          dly_i,
	input  wire logic                fail_i,
	input  wire logic                stall_i,
	// controller side
	input  wire logic                tx_pending_i,
	input  wire logic [FIFO_W-1:0]   tx_fifo_sel_i,
	input  wire logic [NUM_FIFO-1:0] abort_req_i,
	output logic      [NUM_FIFO-1:0] msg_done_o,
	output logic      [NUM_FIFO-1:0] msg_aborted_o,
	output logic      [NUM_FIFO-1:0] all_sent_o,
	output logic      [NUM_FIFO-1:0] lost_arb_o,
	output logic      [NUM_FIFO-1:0] tx_bus_err_o
);
	logic                busy;
	logic                abt;
	logic                ab;
	logic [7:0]          cnt;
	logic [FIFO_W-1:0]   cur;
	logic [NUM_FIFO-1:0] one;

	// outcome of the current message
	assign one = NUM_FIFO'(1) << cur;
	assign ab  = fail_i | abt | abort_req_i[cur];

	// one message at a time: pick the winner, wait, then report
	always_ff @(posedge clk_i)
	begin
		msg_done_o    <= '0;
		msg_aborted_o <= '0;
		all_sent_o    <= '0;
		lost_arb_o    <= '0;
		tx_bus_err_o  <= '0;
		if (rst_i)
		begin
			busy <= 1'b0;
			cnt  <= 8'h00;
			abt  <= 1'b0;
			cur  <= '0;
		end
		else if (cnt != 8'h00)
		begin
			cnt <= cnt - 8'h01;
			abt <= abt | abort_req_i[cur];
		end
		else if (busy)
		begin
			busy          <= 1'b0;
			cnt           <= 8'h03;                 // gap so the request drops
			lost_arb_o    <= fail_i ? one : '0;
			tx_bus_err_o  <= fail_i ? one : '0;
			msg_aborted_o <= ab ? one : '0;
			msg_done_o    <= ab ? '0 : one;
			all_sent_o    <= ab ? '0 : one;
		end
		else if (tx_pending_i && !stall_i)
		begin
			busy <= 1'b1;
			abt  <= 1'b0;
			cur  <= tx_fifo_sel_i;
			cnt  <= dly_i;
		end
	end
endmodule
`default_nettype wire

// >>> verif/can_int_fifo_ctl_checker.sv
`timescale 1ns/1ps
`default_nettype none
module can_int_fifo_ctl_checker
	import can_ctl_pkg::*;
(
	// clock and reset
	input  wire logic                clk_i,
	input  wire logic                rst_i,
	// register bus
	input  wire logic                wb_cyc_i,
	input  wire logic                wb_stb_i,
	input  wire logic                wb_we_i,
	input  wire logic [ADR_W-1:0]    wb_adr_i,
	input  wire logic                wb_ack_o,
	// engine side
	input  wire logic [NUM_FIFO-1:0] msg_aborted_i,
	input  wire logic [NUM_FIFO-1:0] all_sent_i,
	input  wire logic [NUM_FIFO-1:0] remote_rx_i,
	input  wire logic [2:0]          operating_mode_field_o,
	input  wire logic [31:0]         buffer_base_addr_o,
	input  wire logic [NUM_FIFO-1:0] send_request_o,
	input  wire logic [NUM_FIFO-1:0] abort_req_o,
	input  wire logic [NUM_FIFO-1:0] fifo_reset_o,
	input  wire logic                tx_pending_o
);
	// ------------------------------------------------------------
	// properties
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	logic take0;

	// software write to fifo 0 taken this cycle
	assign take0 = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i
		&& wb_adr_i == OFS_FIFO_LO;

	// bus handshake
	a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held too long");
	a_ack_on_take: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("request not acked");
	a_no_stray_ack: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
		else $error("ack without request");
	// base address and mode
	a_mode_after_reset: assert property (
		$fell(rst_i) |-> operating_mode_field_o == MODE_CONFIG)
		else $error("not in configuration mode after reset");
	a_base_aligned: assert property (buffer_base_addr_o[1:0] == 2'h0)
		else $error("base address not word aligned");
	a_base_cfg_only: assert property (!$stable(buffer_base_addr_o) |->
		$past(operating_mode_field_o) == MODE_CONFIG
		|| $past(operating_mode_field_o, 2) == MODE_CONFIG)
		else $error("base changed outside configuration mode");
	// send request of fifo 0, and pending over all fifos
	a_sent_clears: assert property (
		all_sent_i[0] && !take0 && !remote_rx_i[0]
		|=> !send_request_o[0])
		else $error("request kept after all sent");
	a_abort_clears: assert property (
		msg_aborted_i[0] && !take0 && !remote_rx_i[0]
		|=> !send_request_o[0])
		else $error("request kept after abort");
	a_abort_pulse: assert property (abort_req_o[0] |=> !abort_req_o[0])
		else $error("abort request longer than one cycle");
	a_reset_clears: assert property (
		fifo_reset_o[0] |=> !fifo_reset_o[0] && !send_request_o[0])
		else $error("fifo reset did not clear the request");
	a_pending_lag: assert property (
		tx_pending_o == $past(|send_request_o))
		else $error("pending does not follow requests");

	// main scenarios
	c_abort: cover property (abort_req_o[0]);
	c_sent: cover property (all_sent_i[0]);
	c_aborted: cover property (msg_aborted_i[0]);
	c_fifo_reset: cover property (fifo_reset_o[0]);
endmodule
bind can_int_fifo_ctl can_int_fifo_ctl_checker u_can_int_fifo_ctl_checker (
	.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_ack_o,
	.msg_aborted_i, .all_sent_i, .remote_rx_i, .operating_mode_field_o,
	.buffer_base_addr_o, .send_request_o, .abort_req_o, .fifo_reset_o,
	.tx_pending_o);
`default_nettype wire

// >>> verif/tb_can_int_fifo_ctl.sv
`timescale 1ns/1ps
`default_nettype none
module tb_can_int_fifo_ctl
	import can_ctl_pkg::*;
;
	// ------------------------------------------------------------
	// bench signals and tasks
	// ------------------------------------------------------------
	localparam logic [ADR_W-1:0] F0 = OFS_FIFO_LO;
	localparam logic [ADR_W-1:0] F1 = OFS_FIFO_LO + 12'h004;
	localparam logic [ADR_W-1:0] F2 = OFS_FIFO_LO + 12'h008;
	logic                     clk_i = 1'b0;
	logic                     rst_i = 1'b1;
	logic                     cyc   = 1'b0;
	logic                     we    = 1'b0;
	logic [ADR_W-1:0]         adr   = '0;
	logic [31:0]              wdat  = '0;
	logic [31:0]              rdat;
	logic [NUM_SRC-1:0]       ev    = '0;
	logic [NUM_FIFO-1:0]      rmt   = '0;
	logic [FIFO_W-1:0]        asel  = '0;
	logic [7:0]               dly   = 8'h02;
	logic                     fail  = 1'b0;
	logic                     stall = 1'b0;
	int                       failures = 0;
	int                       n_tests  = 0;
	wire logic [31:0]         dat_o, faddr;
	wire logic                ack, irq, tpend, mon;
	wire logic [FIFO_W-1:0]   tsel;
	wire logic [NUM_FIFO-1:0] sreq, abrq, done, abtd, alls, larb, terr;

	// clock
	always #2.5 clk_i = ~clk_i;

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e)
		begin
			failures++;
			$display("Error %0t: got %h expected %h", $time, g, e);
		end
	endtask

	// one classic cycle, held until ack is sampled
	task automatic bus(input logic w, input logic [ADR_W-1:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		cyc  <= 1'b1;
		we   <= w;
		adr  <= a;
		wdat <= d;
		do
		begin
			@(posedge clk_i);
			n++;
		end
		while (ack !== 1'b1 && n < 20);
		rdat = dat_o;
		cyc <= 1'b0;
		if (n >= 20)
			chk(32'(ack), 32'h1);
		@(posedge clk_i);
	endtask

	task automatic rd(input logic [ADR_W-1:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(rdat, e);
	endtask

	task automatic idle(input int f);
		int n;
		n = 0;
		while (sreq[f] !== 1'b0 && n < 300)
		begin
			@(posedge clk_i);
			n++;
		end
		chk(32'(sreq[f]), 32'h0);
	endtask

	task automatic results;
		$display("Compares %0d, mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// design and far side
	can_int_fifo_ctl u_can_int_fifo_ctl (.clk_i(clk_i), .rst_i(rst_i),
		.wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
		.irq_event_i(ev), .msg_done_i(done), .msg_aborted_i(abtd),
		.all_sent_i(alls), .lost_arb_i(larb), .tx_bus_err_i(terr),
		.remote_rx_i(rmt), .addr_sel_i(asel), .fifo_addr_o(faddr),
		.irq_o(irq), .operating_mode_field_o(), .module_on_o(mon),
		.buffer_base_addr_o(), .send_request_o(sreq), .abort_req_o(abrq),
		.fifo_reset_o(), .tx_fifo_sel_o(tsel), .tx_pending_o(tpend));
	can_engine_model u_can_engine_model (.clk_i(clk_i), .rst_i(rst_i),
		.dly_i(dly), .fail_i(fail), .stall_i(stall), .tx_pending_i(tpend),
		.tx_fifo_sel_i(tsel), .abort_req_i(abrq), .msg_done_o(done),
		.msg_aborted_o(abtd), .all_sent_o(alls), .lost_arb_o(larb),
		.tx_bus_err_o(terr));

	// watchdog
	initial
	begin
		#100000;
		failures++;
		results();
	end

	// ------------------------------------------------------------
	// tests
	// ------------------------------------------------------------
	initial
	begin
		int p;
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		rd(OFS_INT, 32'h0);
		rd(OFS_CON, 32'h0080_0000);
		rd(12'h040, 32'h0);
		$display("test reset done");
		bus(1'b1, OFS_INT, 32'hFFFF_FFFF);
		rd(OFS_INT, 32'hF80F_E80F);
		chk(32'(irq), 32'h1);
		for (int k = 0; k < NUM_SRC; k++)
		begin
			p = (k < 4) ? k : k + 7;
			bus(1'b1, OFS_INT, 32'h1 << (p + 16));
			ev <= NUM_SRC'(1) << k;
			@(posedge clk_i);
			ev <= '0;
			repeat (2) @(posedge clk_i);
			chk(32'(irq), 32'h1);
			rd(OFS_INT, (32'h1 << (p + 16)) | (32'h1 << p)
				| ((k > 5) ? 32'h1000 : 32'h0));
		end
		bus(1'b1, OFS_INT, 32'h0);
		bus(1'b1, OFS_CON, 32'h0080_8000);
		chk(32'(mon), 32'h1);
		bus(1'b1, OFS_CON, 32'h0080_0000);
		chk(32'(mon), 32'h0);
		rd(OFS_INT, 32'h0);
		chk(32'(irq), 32'h0);
		$display("test interrupts done");
		bus(1'b1, OFS_BASE, 32'hFFFF_FFFF);
		rd(OFS_BASE, 32'hFFFF_FFFC);
		bus(1'b1, OFS_BASE, 32'h1000_0000);
		bus(1'b1, F0, 32'h0003_0083);
		bus(1'b1, F1, 32'h0000_0001);
		bus(1'b1, F2, 32'h0000_0082);
		asel <= 5'h02;
		repeat (2) @(posedge clk_i);
		chk(faddr, 32'h1000_0050);
		bus(1'b1, OFS_CON, 32'h0);
		bus(1'b1, OFS_BASE, 32'h2000_0000);
		rd(OFS_BASE, 32'h1000_0000);
		bus(1'b1, F0, 32'h0007_0003);
		rd(F0, 32'h0003_0083);
		$display("test layout done");
		bus(1'b1, F0, 32'h0003_008B);
		idle(0);
		rd(F0, 32'h0003_0083);
		dly <= 8'd30;
		bus(1'b1, F0, 32'h0003_008B);
		bus(1'b1, F0, 32'h0003_0083);
		idle(0);
		rd(F0, 32'h0003_00C3);
		fail <= 1'b1;
		dly  <= 8'd2;
		bus(1'b1, F0, 32'h0003_008B);
		idle(0);
		rd(F0, 32'h0003_00F3);
		rd(F0, 32'h0003_00C3);
		bus(1'b1, F0, 32'h0003_008B);
		idle(0);
		bus(1'b1, F0, 32'h0003_4083);
		rd(F0, 32'h0003_0083);
		fail <= 1'b0;
		$display("test transmit done");
		bus(1'b1, F1, 32'h0000_0009);
		rd(F1, 32'h0000_0001);
		bus(1'b1, F0, 32'h0003_0087);
		rmt <= 32'h0000_0005;
		@(posedge clk_i);
		rmt <= '0;
		@(posedge clk_i);
		chk(32'(sreq[2:0]), 32'h1);
		idle(0);
		rd(F0, 32'h0003_0087);
		$display("test remote done");
		stall <= 1'b1;
		bus(1'b1, F2, 32'h0000_008A);
		bus(1'b1, F0, 32'h0003_008B);
		chk(32'(tsel), 32'h0);
		bus(1'b1, F0, 32'h0003_0088);
		chk(32'(tsel), 32'h2);
		stall <= 1'b0;
		idle(0);
		idle(2);
		rd(F2, 32'h0000_0082);
		$display("test priority done");
		results();
	end
endmodule
`default_nettype wire
